// >>> moalu_pkg.sv
// Package for the memory-operand ALU execution block.
// Assumes a single 100 MHz clock; one T state lasts four clock cycles.
package moalu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] MOALU_OFS_CTRL = 8'h00;
  localparam logic [7:0] MOALU_OFS_STAT = 8'h04;
  localparam logic [7:0] MOALU_OFS_ACC = 8'h08;
  localparam logic [7:0] MOALU_OFS_PAIRS = 8'h0c;
  localparam logic [7:0] MOALU_OFS_ALT = 8'h10;
  localparam logic [7:0] MOALU_OFS_IDX = 8'h14;
  localparam logic [7:0] MOALU_OFS_SP = 8'h18;
  localparam logic [7:0] MOALU_OFS_CNT = 8'h1c;
  localparam logic [7:0] MOALU_OFS_MEM = 8'h20;
  localparam logic [7:0] MOALU_OFS_CTR = 8'h24;
  localparam logic [7:0] MOALU_OFS_TGT = 8'h28;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int MOALU_CTRL_OP0 = 0;
  localparam int MOALU_CTRL_OP1 = 8;
  localparam int MOALU_CTRL_DISP = 16;
  localparam int MOALU_CTRL_PFX = 24;
  localparam int MOALU_CTRL_GO = 31;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] MOALU_OP_ADD = 8'h86;
  localparam logic [7:0] MOALU_OP_ADC = 8'h8e;
  localparam logic [7:0] MOALU_OP_SUB = 8'h96;
  localparam logic [7:0] MOALU_OP_XOR = 8'hae;
  localparam logic [7:0] MOALU_OP_CMP = 8'hbe;
  localparam logic [7:0] MOALU_OP_INC = 8'h34;
  localparam logic [7:0] MOALU_OP_DEC = 8'h35;
  localparam logic [7:0] MOALU_OP_BITPFX = 8'hcb;
  localparam logic [7:0] MOALU_OP_RR = 8'h1e;
  localparam logic [7:0] MOALU_OP_SLA = 8'h26;
  localparam logic [7:0] MOALU_OP_SRA = 8'h2e;
  localparam logic [7:0] MOALU_OP_SRL = 8'h3e;
  localparam logic [7:0] MOALU_OP_EXX = 8'hd9;
  localparam logic [7:0] MOALU_OP_EXSP = 8'he3;
  localparam logic [7:0] MOALU_PFX_MASK = 8'hdf;
  localparam logic [7:0] MOALU_PFX_VAL = 8'hdd;
  localparam int MOALU_IDX_SEL_BIT = 5;

  // ----------------------------------------------------------------
  // Flag positions
  // ----------------------------------------------------------------
  localparam int MOALU_F_C = 0;
  localparam int MOALU_F_N = 1;
  localparam int MOALU_F_PV = 2;
  localparam int MOALU_F_H = 4;
  localparam int MOALU_F_Z = 6;
  localparam int MOALU_F_S = 7;

  // ----------------------------------------------------------------
  // Timing (T states per instruction, clocks per T state)
  // ----------------------------------------------------------------
  localparam logic [4:0] MOALU_T_PLAIN = 5'd7;
  localparam logic [4:0] MOALU_T_IDX = 5'd19;
  localparam logic [4:0] MOALU_T_RMW = 5'd11;
  localparam logic [4:0] MOALU_T_IDX_RMW = 5'd23;
  localparam logic [4:0] MOALU_T_BIT = 5'd15;
  localparam logic [4:0] MOALU_T_EXSP = 5'd19;
  localparam logic [4:0] MOALU_T_EXX = 5'd4;
  localparam logic [4:0] MOALU_T_BAD = 5'd4;
  localparam logic [7:0] MOALU_TSTATE_DIV = 8'd4;

  typedef enum logic [1:0] {MOALU_IDLE, MOALU_RUN} moalu_state_e;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic [15:0] mem_ptr;
    logic [15:0] counter;
    logic [15:0] target;
    logic [15:0] alt_mem_ptr;
    logic [15:0] alt_counter;
    logic [15:0] alt_target;
    logic [15:0] idx_first;
    logic [15:0] idx_second;
    logic [15:0] stack_ptr;
  } moalu_regs_s;

  typedef struct packed {
    moalu_state_e state;
    moalu_regs_s regs;
    logic [31:0] ctrl;
    logic [4:0] tleft;
    logic [7:0] div;
    logic bad_op;
    logic [7:0] mem_lo;
    logic [7:0] mem_hi;
    logic data_ph;
    logic data_wr;
    logic [7:0] data_addr;
    logic [31:0] rdata;
  } moalu_all_s;

endpackage : moalu_pkg

// >>> moalu_core.sv
// Memory-operand ALU execution unit with an AHB-Lite register port.
// Assumes a single-master AHB-Lite bus; the memory operand and the two
// stacked bytes are held in registers that software loads before a run.
`timescale 1ns/100ps

// Overview of operation
// [RL1] 86: add memory_pointer_pair byte to accumulator, 7 T states.
// [RL2] Add: half-carry from bit 3, carry from bit 7, subtract flag cleared.
// [RL3] Add-with-carry adds operand plus carry; indexed form 19 T states.
// [RL4] Subtract: half-carry from bit 4 borrow, subtract flag set, carry=borrow.
// [RL5] Add, adc, subtract, compare set overflow on signed range excess.
// [RL6] Exclusive-OR memory byte into the accumulator.
// [RL7] Compare BE sets flags from subtraction only, 7 T states.
// [RL8] Prefix 11x11101 bit 5 selects index; indexed compare 19 T states.
// [RL9] 34 increments memory byte and writes back, 11 T states.
// [RL10] Increment: overflow only from 7F, half-carry bit 3, N cleared, carry kept.
// [RL11] Indexed increment uses index plus displacement, 23 T states.
// [RL12] Decrement: overflow only from 80, half-carry bit 4 borrow, N set.
// [RL13] Rotate right: carry from bit 0, H and N cleared, even parity flag.
// [RL14] CB-prefixed forms on memory pointer take 15 T states.
// [RL15] Indexed CB forms: prefix, CB, displacement, operation; 23 T states. Code takes the operation from the displacement byte.
// [RL16] Shift left arith: carry from bit 7, H and N cleared, parity.
// [RL17] Shift right logical: sign cleared, zero, H N cleared, carry bit 0.
// [RL18] swap_all_pairs exchanges three pairs with alternate bank.
// [RL19] E3 swaps pointer pair with two stacked bytes, flags kept, 19 T.
// [RL20] Indexed E3 swaps selected index register, 23 T states.
// [RL21] Compare leaves the accumulator unchanged.
// [RL22] Flags without defined effect keep their previous values.
module moalu_core
  import moalu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic busy,
  output logic [15:0] operand_addr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  moalu_all_s q;
  moalu_all_s d;

  logic [7:0] op0;
  logic [7:0] op1;
  logic [7:0] disp;
  logic [7:0] pfx;
  logic indexed;
  logic [15:0] idx_val;
  logic [15:0] eff_addr;

  // Every prefix byte has its top bit set, so that bit is implied here and the
  // top bit of the control word stays free to act as go
  assign pfx = {1'b1, q.ctrl[MOALU_CTRL_PFX +: 7]};
  assign op0 = q.ctrl[MOALU_CTRL_OP0 +: 8];
  assign op1 = q.ctrl[MOALU_CTRL_OP1 +: 8];
  assign disp = q.ctrl[MOALU_CTRL_DISP +: 8];
  assign indexed = (pfx & MOALU_PFX_MASK) == MOALU_PFX_VAL; // RL8
  assign idx_val = pfx[MOALU_IDX_SEL_BIT] ? q.regs.idx_second : q.regs.idx_first; // RL8
  assign eff_addr = indexed ? idx_val + {{8{disp[7]}}, disp} : q.regs.mem_ptr; // RL11

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign busy = q.state == MOALU_RUN;
  assign operand_addr = eff_addr;

  // ----------------------------------------------------------------
  // Flag helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] szp(input logic [7:0] r, input logic [7:0] f);
    logic [7:0] o;
    o = f;
    o[MOALU_F_S] = r[7];
    o[MOALU_F_Z] = r == 8'h00;
    o[MOALU_F_PV] = ~^r;
    return o;
  endfunction : szp

  // ----------------------------------------------------------------
  // Execution
  // ----------------------------------------------------------------
  logic [7:0] cur_op;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic [7:0] nf;
  logic wr_acc;
  logic wr_mem;
  logic [4:0] tcount;
  logic legal;
  logic cin;
  logic [7:0] m;
  logic [7:0] a;

  always_comb begin
    cur_op = indexed ? op1 : op0;
    m = q.mem_lo;
    a = q.regs.acc;
    cin = 1'b0;
    sum = 9'h000;
    nib = 5'h00;
    res = 8'h00;
    nf = q.regs.flags; // RL22
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    legal = 1'b1;
    // Refused codes still run a short while so software always sees busy fall
    tcount = MOALU_T_BAD;
    // The indexed bit form reads its operation byte from the displacement field
    if (pfx == MOALU_OP_BITPFX || (indexed && op1 == MOALU_OP_BITPFX)) begin
      tcount = indexed ? MOALU_T_IDX_RMW : MOALU_T_BIT; // RL14 RL15
      wr_mem = 1'b1;
      nf[MOALU_F_H] = 1'b0;
      nf[MOALU_F_N] = 1'b0;
      unique case (indexed ? disp : op0) // RL15
        MOALU_OP_RR: begin
          res = {q.regs.flags[MOALU_F_C], m[7:1]}; // RL13
          nf[MOALU_F_C] = m[0]; // RL13
        end
        MOALU_OP_SLA: begin
          res = {m[6:0], 1'b0}; // RL16
          nf[MOALU_F_C] = m[7]; // RL16
        end
        MOALU_OP_SRA: begin
          res = {m[7], m[7:1]};
          nf[MOALU_F_C] = m[0];
        end
        MOALU_OP_SRL: begin
          res = {1'b0, m[7:1]}; // RL17
          nf[MOALU_F_C] = m[0]; // RL17
        end
        default: begin
          legal = 1'b0;
          wr_mem = 1'b0;
          nf = q.regs.flags;
        end
      endcase
      if (legal) begin
        nf = szp(res, nf); // RL13 RL16 RL17
      end
    end else begin
      unique case (cur_op)
        MOALU_OP_ADD, MOALU_OP_ADC: begin
          cin = (cur_op == MOALU_OP_ADC) & q.regs.flags[MOALU_F_C]; // RL3
          sum = {1'b0, a} + {1'b0, m} + {8'h00, cin}; // RL1
          nib = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
          res = sum[7:0];
          nf = szp(res, nf);
          nf[MOALU_F_H] = nib[4]; // RL2
          nf[MOALU_F_C] = sum[8]; // RL2
          nf[MOALU_F_N] = 1'b0; // RL2
          nf[MOALU_F_PV] = (a[7] == m[7]) && (res[7] != a[7]); // RL5
          wr_acc = 1'b1;
          tcount = indexed ? MOALU_T_IDX : MOALU_T_PLAIN; // RL1 RL3
        end
        MOALU_OP_SUB, MOALU_OP_CMP: begin
          sum = {1'b0, a} - {1'b0, m};
          nib = {1'b0, a[3:0]} - {1'b0, m[3:0]};
          res = sum[7:0];
          nf = szp(res, nf);
          nf[MOALU_F_H] = nib[4]; // RL4 RL7
          nf[MOALU_F_C] = sum[8]; // RL4 RL7
          nf[MOALU_F_N] = 1'b1; // RL4 RL7
          nf[MOALU_F_PV] = (a[7] != m[7]) && (res[7] != a[7]); // RL5
          wr_acc = cur_op == MOALU_OP_SUB; // RL21
          tcount = indexed ? MOALU_T_IDX : MOALU_T_PLAIN; // RL7 RL8
        end
        MOALU_OP_XOR: begin
          res = a ^ m; // RL6
          nf = szp(res, nf);
          nf[MOALU_F_H] = 1'b0;
          nf[MOALU_F_N] = 1'b0;
          nf[MOALU_F_C] = 1'b0;
          wr_acc = 1'b1; // RL6
          tcount = indexed ? MOALU_T_IDX : MOALU_T_PLAIN;
        end
        MOALU_OP_INC: begin
          res = m + 8'h01; // RL9
          nf = szp(res, nf);
          nf[MOALU_F_PV] = m == 8'h7f; // RL10
          nf[MOALU_F_H] = m[3:0] == 4'hf; // RL10
          nf[MOALU_F_N] = 1'b0; // RL10
          wr_mem = 1'b1; // RL9
          tcount = indexed ? MOALU_T_IDX_RMW : MOALU_T_RMW; // RL9 RL11
        end
        MOALU_OP_DEC: begin
          res = m - 8'h01;
          nf = szp(res, nf);
          nf[MOALU_F_PV] = m == 8'h80; // RL12
          nf[MOALU_F_H] = m[3:0] == 4'h0; // RL12
          nf[MOALU_F_N] = 1'b1; // RL12
          wr_mem = 1'b1;
          tcount = indexed ? MOALU_T_IDX_RMW : MOALU_T_RMW;
        end
        MOALU_OP_EXSP: begin
          tcount = indexed ? MOALU_T_IDX_RMW : MOALU_T_EXSP; // RL19 RL20
        end
        MOALU_OP_EXX: begin
          legal = !indexed;
          tcount = MOALU_T_EXX;
        end
        default: begin
          legal = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus decode and sequencing strobes
  // ----------------------------------------------------------------
  logic [7:0] bus_idx;
  logic tick;
  logic bus_take;
  logic bus_read;
  logic bus_write;
  logic start;
  logic finish;
  logic commit;
  logic do_exsp;
  logic do_exx;

  // One T state spans a fixed number of clocks; tick closes each one
  assign tick = q.div == MOALU_TSTATE_DIV - 8'd1;
  assign bus_idx = q.data_addr;
  assign bus_take = hsel && hready && htrans[1];
  assign bus_read = bus_take && !hwrite;
  // Writes landing during a run are dropped so operands cannot change under it
  assign bus_write = q.data_ph && q.data_wr && q.state == MOALU_IDLE;
  assign start = q.state == MOALU_IDLE && q.ctrl[MOALU_CTRL_GO];
  // Results commit on the closing tick of the last T state
  assign finish = q.state == MOALU_RUN && tick && q.tleft == 5'd1;
  assign commit = finish && legal;
  assign do_exsp = cur_op == MOALU_OP_EXSP && pfx != MOALU_OP_BITPFX;
  assign do_exx = cur_op == MOALU_OP_EXX && pfx != MOALU_OP_BITPFX;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  logic [31:0] stat_word;
  logic [31:0] cnt_word;
  logic [31:0] mem_word;
  logic [31:0] rd_word;

  // Busy and refusal sit just above the flags so one read polls all three
  assign stat_word = {22'h000000, q.bad_op, busy, q.regs.flags};
  assign cnt_word = {27'h0000000, q.tleft};
  assign mem_word = {16'h0000, q.mem_hi, q.mem_lo};

  always_comb begin
    unique case (haddr[7:0])
      MOALU_OFS_CTRL: rd_word = q.ctrl;
      MOALU_OFS_STAT: rd_word = stat_word;
      MOALU_OFS_ACC: rd_word = {24'h000000, q.regs.acc};
      MOALU_OFS_PAIRS: rd_word = {16'h0000, q.regs.mem_ptr};
      MOALU_OFS_ALT: rd_word = {16'h0000, q.regs.alt_mem_ptr};
      MOALU_OFS_IDX: rd_word = {q.regs.idx_second, q.regs.idx_first};
      MOALU_OFS_SP: rd_word = {16'h0000, q.regs.stack_ptr};
      MOALU_OFS_CNT: rd_word = cnt_word;
      MOALU_OFS_MEM: rd_word = mem_word;
      MOALU_OFS_CTR: rd_word = {q.regs.alt_counter, q.regs.counter};
      MOALU_OFS_TGT: rd_word = {q.regs.alt_target, q.regs.target};
      default: rd_word = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // Address phase capture
    d.data_ph = bus_take;
    if (bus_take) begin
      d.data_wr = hwrite;
      d.data_addr = haddr[7:0];
    end
    // Read data
    if (bus_read) begin
      d.rdata = rd_word;
    end
    // Register writes are ignored while an instruction runs
    if (bus_write) begin
      unique case (bus_idx)
        MOALU_OFS_CTRL: d.ctrl = hwdata;
        MOALU_OFS_STAT: d.regs.flags = hwdata[7:0];
        MOALU_OFS_ACC: d.regs.acc = hwdata[7:0];
        MOALU_OFS_PAIRS: d.regs.mem_ptr = hwdata[15:0];
        MOALU_OFS_ALT: d.regs.alt_mem_ptr = hwdata[15:0];
        MOALU_OFS_IDX: {d.regs.idx_second, d.regs.idx_first} = hwdata;
        MOALU_OFS_SP: d.regs.stack_ptr = hwdata[15:0];
        MOALU_OFS_MEM: {d.mem_hi, d.mem_lo} = hwdata[15:0];
        MOALU_OFS_CTR: {d.regs.alt_counter, d.regs.counter} = hwdata;
        MOALU_OFS_TGT: {d.regs.alt_target, d.regs.target} = hwdata;
        default: d.rdata = q.rdata;
      endcase
    end
    unique case (q.state)
      MOALU_IDLE: begin
        // Divider restarts so every run is made of whole T states
        d.div = 8'd0;
        if (start) begin
          d.ctrl[MOALU_CTRL_GO] = 1'b0;
          d.bad_op = !legal;
          d.tleft = tcount;
          d.state = MOALU_RUN;
        end
      end
      MOALU_RUN: begin
        d.div = tick ? 8'd0 : q.div + 8'd1;
        if (tick) begin
          d.tleft = q.tleft - 5'd1;
          if (finish) begin
            d.state = MOALU_IDLE;
            if (commit) begin
              d.regs.flags = nf; // RL22
              if (wr_acc) begin
                d.regs.acc = res;
              end
              if (wr_mem) begin
                d.mem_lo = res;
              end
              // The stacked bytes live in MEM; the block owns no memory bus
              if (do_exsp) begin
                {d.mem_hi, d.mem_lo} = indexed ? idx_val : q.regs.mem_ptr; // RL19 RL20
                if (!indexed) begin
                  d.regs.mem_ptr = {q.mem_hi, q.mem_lo}; // RL19
                end else if (pfx[MOALU_IDX_SEL_BIT]) begin
                  d.regs.idx_second = {q.mem_hi, q.mem_lo}; // RL20
                end else begin
                  d.regs.idx_first = {q.mem_hi, q.mem_lo}; // RL20
                end
              end
              if (do_exx) begin
                d.regs.mem_ptr = q.regs.alt_mem_ptr; // RL18
                d.regs.alt_mem_ptr = q.regs.mem_ptr; // RL18
                d.regs.counter = q.regs.alt_counter; // RL18
                d.regs.alt_counter = q.regs.counter; // RL18
                d.regs.target = q.regs.alt_target; // RL18
                d.regs.alt_target = q.regs.target; // RL18
              end
            end
          end
        end
      end
      default: d.state = MOALU_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : moalu_core

// >>> moalu_mem_model.sv
// External memory seen by the block: each byte holds its address low byte.
// Assumes the block presents the effective operand address combinationally.
`timescale 1ns/100ps
module moalu_mem_model
  import moalu_pkg::*;
(
  input wire logic [15:0] addr,
  output logic [7:0] rd_byte
);
  assign rd_byte = addr[7:0];
endmodule : moalu_mem_model

// >>> moalu_core_asserts.sv
// Concurrent checks on the ports of the memory-operand execution unit.
// Assumes one clock domain, hready tied to hreadyout.
`timescale 1ns/100ps
module moalu_core_asserts
  import moalu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic busy,
  input wire logic [15:0] operand_addr
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic aw_q;
  logic [7:0] cnt_q;
  logic go_wr;
  assign go_wr = aw_q && hwdata[31] && !busy;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      aw_q <= hsel && hready && htrans[1] && hwrite && (haddr[7:0] == MOALU_OFS_CTRL);
      cnt_q <= busy ? cnt_q + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_go_start; go_wr |-> ##[1:2] busy; endproperty
  a_go_start: assert property (p_go_start) else $error("busy did not follow go");
  property p_no_stray; $rose(busy) |-> $past(go_wr) || $past(go_wr, 2); endproperty
  a_no_stray: assert property (p_no_stray) else $error("busy rose without go");
  property p_busy_len; $fell(busy) |-> cnt_q inside {8'h10, 8'h1c, 8'h2c, 8'h3c, 8'h4c, 8'h5c};
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("bad run length");
  property p_busy_max; cnt_q <= 8'h5c; endproperty
  a_busy_max: assert property (p_busy_max) else $error("run too long");
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_resp; !hresp; endproperty
  a_resp: assert property (p_resp) else $error("error response");
  property p_rdata_hold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_addr_hold; busy ##1 busy |-> $stable(operand_addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("operand address moved");
  property p_reset_idle; $rose(hresetn) |-> !busy; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("busy after reset");
  c_plain: cover property ($fell(busy) && cnt_q == 8'h1c);
  c_rmw: cover property ($fell(busy) && cnt_q == 8'h2c);
  c_idx: cover property ($fell(busy) && cnt_q == 8'h5c);
endmodule : moalu_core_asserts

bind moalu_core moalu_core_asserts chk (.*);

// >>> memory_operand_alu_ops_test.sv
// Self-checking bench for the memory-operand execution unit over AHB-Lite.
// Assumes zero-wait slave; the operand byte comes from the memory model.
`timescale 1ns/100ps
module memory_operand_alu_ops_test;
  import moalu_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, d;
  logic [15:0] oa;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, busy;
  wire logic [15:0] operand_addr;
  wire logic [7:0] mem_byte;
  int n_mismatch = 0, num_checks = 0, blen = 0, last_len = 0;
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    blen <= busy ? blen + 1 : 0;
    if (!busy && blen != 0) last_len <= blen;
  end
  moalu_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .busy(busy),
    .operand_addr(operand_addr));
  moalu_mem_model mem (.addr(operand_addr), .rd_byte(mem_byte));
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task rdy;
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      results();
    end
  endtask : rdy
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    r = hrdata;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v, d);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] v);
    xfer(1'b0, a, 32'h0, v);
  endtask : rd
  task run(input logic [31:0] c);
    int i;
    c[MOALU_CTRL_GO] = 1'b1;
    wr(MOALU_OFS_CTRL, c);
    repeat (2) @(posedge hclk);
    oa = operand_addr;
    for (i = 0; i < 100; i++) begin
      rd(MOALU_OFS_STAT, d);
      if (d[8] === 1'b0) break;
    end
    if (i == 100) begin
      n_mismatch++;
      results();
    end
  endtask : run
  task op(input logic [31:0] c, input logic [7:0] a, m, f, ea, em, ef, input int len,
          input logic [15:0] eoa);
    // Plain control word so the model serves the byte at the pointer
    wr(MOALU_OFS_CTRL, 32'h0);
    wr(MOALU_OFS_PAIRS, {16'h0, 8'h40, m});
    wr(MOALU_OFS_ACC, {24'h0, a});
    wr(MOALU_OFS_STAT, {24'h0, f});
    wr(MOALU_OFS_MEM, {24'h0, mem_byte});
    run(c);
    rd(MOALU_OFS_ACC, d);
    chk("acc", {24'h0, ea}, d);
    rd(MOALU_OFS_STAT, d);
    chk("stat", {24'h0, ef}, {22'h0, d[9:0]});
    rd(MOALU_OFS_MEM, d);
    chk("mem", {24'h0, em}, {24'h0, d[7:0]});
    chk("cycles", 32'(len * 4), 32'(last_len));
    chk("addr", {16'h0, eoa}, {16'h0, oa});
    $display("test %h done", c);
  endtask : op
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(MOALU_OFS_STAT, d);
    chk("stat_reset", 32'h0, d);
    rd(8'h3c, d);
    chk("unmapped", 32'h0, d);
    op(32'h86, 8'h7f, 8'h01, 8'h00, 8'h80, 8'h01, 8'h94, 7, 16'h4001);
    op(32'h86, 8'h80, 8'h80, 8'h00, 8'h00, 8'h80, 8'h45, 7, 16'h4080);
    op(32'h8e, 8'h0f, 8'h00, 8'h01, 8'h10, 8'h00, 8'h10, 7, 16'h4000);
    op(32'h96, 8'h10, 8'h01, 8'h00, 8'h0f, 8'h01, 8'h12, 7, 16'h4001);
    op(32'h96, 8'h00, 8'h01, 8'h00, 8'hff, 8'h01, 8'h93, 7, 16'h4001);
    op(32'hae, 8'h5a, 8'hff, 8'h01, 8'ha5, 8'hff, 8'h84, 7, 16'h40ff);
    op(32'hbe, 8'h80, 8'h01, 8'h00, 8'h80, 8'h01, 8'h16, 7, 16'h4001);
    op(32'h34, 8'h33, 8'h7f, 8'h01, 8'h33, 8'h80, 8'h95, 11, 16'h407f);
    op(32'h35, 8'h33, 8'h80, 8'h01, 8'h33, 8'h7f, 8'h17, 11, 16'h4080);
    op(32'hcb00001e, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h45, 15, 16'h4001);
    op(32'hcb00001e, 8'h00, 8'h02, 8'h01, 8'h00, 8'h81, 8'h84, 15, 16'h4002);
    op(32'hcb000026, 8'h00, 8'h81, 8'h00, 8'h00, 8'h02, 8'h01, 15, 16'h4081);
    op(32'hcb00003e, 8'h00, 8'h81, 8'h80, 8'h00, 8'h40, 8'h01, 15, 16'h4081);
    wr(MOALU_OFS_IDX, 32'h200010fe);
    op(32'hdd02be00, 8'h05, 8'h05, 8'h00, 8'h05, 8'h05, 8'h42, 19, 16'h1100);
    op(32'hfd02be00, 8'h05, 8'h05, 8'h00, 8'h05, 8'h05, 8'h42, 19, 16'h2002);
    op(32'hdd028e00, 8'h0f, 8'h00, 8'h01, 8'h10, 8'h00, 8'h10, 19, 16'h1100);
    op(32'hdd023400, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h80, 8'h94, 23, 16'h1100);
    op(32'hdd1ecb00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h45, 23, 16'h111c);
    wr(MOALU_OFS_PAIRS, 32'h1111);
    wr(MOALU_OFS_ALT, 32'h2222);
    wr(MOALU_OFS_CTR, 32'h44443333);
    wr(MOALU_OFS_TGT, 32'h66665555);
    run(32'hd9);
    rd(MOALU_OFS_PAIRS, d);
    chk("pairs", 32'h2222, {16'h0, d[15:0]});
    rd(MOALU_OFS_ALT, d);
    chk("alt", 32'h1111, {16'h0, d[15:0]});
    rd(MOALU_OFS_CTR, d);
    chk("ctr", 32'h33334444, d);
    rd(MOALU_OFS_TGT, d);
    chk("tgt", 32'h55556666, d);
    $display("test swap done");
    wr(MOALU_OFS_PAIRS, 32'h1234);
    wr(MOALU_OFS_MEM, 32'habcd);
    wr(MOALU_OFS_STAT, 32'hd7);
    run(32'he3);
    rd(MOALU_OFS_PAIRS, d);
    chk("pairs_sp", 32'habcd, {16'h0, d[15:0]});
    rd(MOALU_OFS_MEM, d);
    chk("mem_sp", 32'h1234, {16'h0, d[15:0]});
    rd(MOALU_OFS_STAT, d);
    chk("stat_sp", 32'hd7, {22'h0, d[9:0]});
    chk("cycles_sp", 32'd76, 32'(last_len));
    $display("test exchange done");
    wr(MOALU_OFS_MEM, 32'h5678);
    run(32'hfd00e300);
    rd(MOALU_OFS_IDX, d);
    chk("idx_sp", 32'h567810fe, d);
    rd(MOALU_OFS_MEM, d);
    chk("mem_idx_sp", 32'h2000, {16'h0, d[15:0]});
    chk("cycles_idx_sp", 32'd92, 32'(last_len));
    $display("test index exchange done");
    results();
  end
endmodule : memory_operand_alu_ops_test
